// File: lhcd_core.sv
// Command decoder core of the character display controller.
// How it works
// RL1: Two 8-bit registers: command and data.
// RL2: Select 0 command, 1 data register.
// RL3: Direction bit 0 write, 1 read.
// RL4: Command read returns busy and counter.
// RL5: Data register is readable and writable.
// RL6: Serial host precedes payload with control byte.
// RL7: Control bit 7 set means more follow.
// RL8: Control bit 6 selects register, rest zero.
// RL9: Serial direction comes from address byte.
// RL10: Busy high during whole execution.
// RL11: While busy only status read executes.
// RL12: Host polls busy or waits maximum time.
// RL13: Execution 3 cycles, clear 165, status 0.
// RL14: Command bits map straight to bus lines.
// RL15: Set-select bit chooses extended or standard.
// RL16: Nop and function set in both modes.
// RL17: Standard mode command decode.
// RL18: Extended mode command decode.
// RL19: Data register prefetched before a read.
// RL20: Address steps by one after writes.
// RL21: Display shifts with each text write.
// RL22: Cursor shown at counter text position.
// RL23: Function set width, lines, mux, set.
// RL24: Busy on line 7, counter below.
// RL25: Counter steps after read or write.
// RL26: After read, step and refill data.
// RL27: Reserved extended code changes nothing.
// RL28: Down-counter holds busy while non-zero.
`include "lhcd_regs.svh"
module lhcd_core
	import lhcd_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Parallel host port
	input  wire logic       par_stb,
	input  wire logic       par_reg_sel,
	input  wire logic       par_rd,
	input  wire logic [7:0] par_wdata,
	// Serial host port
	input  wire logic       ser_start,
	input  wire logic       ser_rw,
	input  wire logic       ser_valid,
	input  wire logic [7:0] ser_byte,
	input  wire logic       ser_rd_req,
	// Read data and status
	output logic [7:0]      host_rdata,
	output logic            busy_bit,
	output logic [6:0]      addr_counter,
	// Display side
	output lhcd_cfg_t       cfg,
	output logic            disp_shift_pulse,
	output logic            disp_shift_left,
	output logic            home_pulse,
	output logic            cursor_underline,
	output logic            cursor_blinking,
	output logic [6:0]      cursor_addr
);

	// ======================================================================
	// Request merge
	lhcd_req_t ser_req;
	lhcd_req_t req;

	lhcd_ser u_ser (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.ser_start  (ser_start),
		.ser_rw     (ser_rw),
		.ser_valid  (ser_valid),
		.ser_byte   (ser_byte),
		.ser_rd_req (ser_rd_req),
		.req        (ser_req)
	);

	always_comb begin
		if (par_stb) begin
			// RL14: bus lines map to command bits.
			req = '{valid: 1'b1, reg_sel: par_reg_sel, rd: par_rd, data: par_wdata};
		end else begin
			req = ser_req;
		end
	end

	// ======================================================================
	// Text and glyph RAM
	logic       ram_we;
	logic [7:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;

	lhcd_ram #(.AW(8)) u_ram (
		.ref_clk (ref_clk),
		.we      (ram_we),
		.addr    (ram_addr),
		.wdata   (ram_wdata),
		.rdata   (ram_rdata)
	);

	// ======================================================================
	// Decoder state
	lhcd_core_t s;
	lhcd_core_t next_s;
	logic       busy;
	logic       acc_cmd;
	logic       acc_wr;
	logic       acc_rd;
	logic       acc_stat;
	logic       acc_clear;
	logic       acc_short;
	logic       acc_fset;
	logic [7:0] c;
	logic [6:0] ac_step;

	// RL28: busy while counter non-zero.
	assign busy = (s.busy_cnt != 8'h00);
	assign c = req.data;
	assign ac_step = s.cfg.entry_inc ? s.ac + 7'h01 : s.ac - 7'h01;

	// RL2 RL3: select and direction.
	// RL11: only status read while busy.
	assign acc_cmd  = req.valid && !busy && req.reg_sel == `LHCD_SEL_INSTR && req.rd == `LHCD_DIR_WRITE;
	assign acc_wr   = req.valid && !busy && req.reg_sel == `LHCD_SEL_DATA && req.rd == `LHCD_DIR_WRITE;
	assign acc_rd   = req.valid && !busy && req.reg_sel == `LHCD_SEL_DATA && req.rd == `LHCD_DIR_READ;
	assign acc_stat = req.valid && req.reg_sel == `LHCD_SEL_INSTR && req.rd == `LHCD_DIR_READ;
	assign acc_clear = acc_cmd && !s.cfg.ext_mode && c == `LHCD_CMD_CLEAR;
	assign acc_fset  = acc_cmd && c[7:5] == 3'b001 && !c[3];

	always_comb begin
		next_s = s;
		acc_short = 1'b0;
		ram_we = 1'b0;
		ram_addr = {s.sel_glyph, s.ac};
		ram_wdata = req.data;
		next_s.shift_pulse = 1'b0;
		next_s.home_pulse = 1'b0;
		next_s.fetch_req = 1'b0;
		next_s.fetch_load = s.fetch_req;
		// RL13: counter runs down each cycle.
		if (busy) begin
			next_s.busy_cnt = s.busy_cnt - 8'h01;
		end
		// Clear fills the text RAM with blanks.
		if (s.clearing) begin
			ram_we = 1'b1;
			ram_addr = {1'b0, s.clr_idx};
			ram_wdata = `LHCD_BLANK_CHAR;
			next_s.clr_idx = s.clr_idx + 7'h01;
			next_s.clearing = (s.clr_idx != 7'h7F);
		end else if (s.fetch_req) begin
			ram_addr = {s.sel_glyph, s.ac};
		end
		// RL26: refill data register from RAM.
		if (s.fetch_load) begin
			next_s.data_reg = ram_rdata;
		end
		// RL4: status read, takes no time.
		if (acc_stat) begin
			// RL24: busy on line 7, counter below.
			next_s.rdata = {busy, s.ac};
		end
		// RL5: data register read and write.
		if (acc_rd) begin
			// RL19: read returns prefetched byte.
			next_s.rdata = s.data_reg;
			// RL25: step after read.
			next_s.ac = ac_step;
			next_s.fetch_req = 1'b1;
			acc_short = 1'b1;
		end
		if (acc_wr && !s.clearing) begin
			ram_we = 1'b1;
			ram_addr = {s.sel_glyph, s.ac};
			// RL20: step after write.
			next_s.ac = ac_step;
			// RL21: shift with text write.
			if (s.cfg.entry_shift && !s.sel_glyph) begin
				next_s.shift_pulse = 1'b1;
				next_s.shift_left = s.cfg.entry_inc;
			end
			acc_short = 1'b1;
		end
		// RL1: command register latches accepted codes.
		if (acc_cmd) begin
			next_s.ir = c;
			// RL16: common commands.
			if (c == `LHCD_CMD_NOP) begin
				acc_short = 1'b1;
			end else if (acc_fset) begin
				// RL23: function set fields.
				next_s.cfg.bus_width_sel = c[`LHCD_FS_WIDTH_BIT];
				next_s.cfg.two_lines = c[`LHCD_FS_LINES_BIT];
				next_s.cfg.low_mux_sel = c[`LHCD_FS_MUX_BIT];
				// RL15: instruction set select.
				next_s.cfg.ext_mode = c[`LHCD_FS_EXT_BIT];
				acc_short = 1'b1;
			end else if (!s.cfg.ext_mode) begin
				// RL17: standard mode decode.
				if (c == `LHCD_CMD_CLEAR) begin
					next_s.ac = 7'h00;
					next_s.sel_glyph = 1'b0;
					next_s.clearing = 1'b1;
					next_s.clr_idx = 7'h00;
					next_s.cfg.entry_inc = 1'b1;
				end else if (c[7:1] == 7'b0000001) begin
					next_s.ac = 7'h00;
					next_s.sel_glyph = 1'b0;
					next_s.home_pulse = 1'b1;
					acc_short = 1'b1;
				end else if (c[7:2] == 6'b000001) begin
					next_s.cfg.entry_inc = c[1];
					next_s.cfg.entry_shift = c[0];
					acc_short = 1'b1;
				end else if (c[7:3] == 5'b00001) begin
					next_s.cfg.display_on = c[2];
					next_s.cfg.cursor_on = c[1];
					next_s.cfg.cursor_blink = c[0];
					acc_short = 1'b1;
				end else if (c[7:4] == 4'b0001 && c[1:0] == 2'b00) begin
					if (c[3]) begin
						next_s.shift_pulse = 1'b1;
						next_s.shift_left = !c[2];
					end else begin
						next_s.ac = c[2] ? s.ac + 7'h01 : s.ac - 7'h01;
					end
					acc_short = 1'b1;
				end else if (c[7:6] == 2'b01) begin
					next_s.ac = {s.ac[6], c[5:0]};
					next_s.sel_glyph = 1'b1;
					next_s.fetch_req = 1'b1;
					acc_short = 1'b1;
				end else if (c[7]) begin
					next_s.ac = c[6:0];
					next_s.sel_glyph = 1'b0;
					next_s.fetch_req = 1'b1;
					acc_short = 1'b1;
				end
			end else begin
				// RL18: extended mode decode.
				if (c[7:1] == 7'b0000001) begin
					next_s.cfg.screen_l = c[0];
					acc_short = 1'b1;
				end else if (c[7:2] == 6'b000001) begin
					next_s.cfg.disp_p = c[1];
					next_s.cfg.disp_q = c[0];
					acc_short = 1'b1;
				end else if (c[7:3] == 5'b00001) begin
					next_s.cfg.symbol_only_mode = c[2];
					next_s.cfg.symbol_blink = c[1];
					next_s.cfg.direct_drive = c[0];
					acc_short = 1'b1;
				end else if (c[7:2] == 6'b000100) begin
					next_s.cfg.tempco_hi = c[1];
					next_s.cfg.tempco_lo = c[0];
					acc_short = 1'b1;
				end else if (c[7:2] == 6'b010000) begin
					next_s.cfg.pump_hi = c[1];
					next_s.cfg.pump_lo = c[0];
					acc_short = 1'b1;
				end else if (c[7]) begin
					if (c[6]) begin
						next_s.cfg.level_b = c[5:0];
					end else begin
						next_s.cfg.level_a = c[5:0];
					end
					acc_short = 1'b1;
				end
				// RL27: reserved code falls through untouched.
			end
		end
		// RL10: busy for the execution time.
		if (acc_clear) begin
			next_s.busy_cnt = `LHCD_CYC_CLEAR;
		end else if (acc_short) begin
			next_s.busy_cnt = `LHCD_CYC_SHORT;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.cfg.entry_inc <= `LHCD_RST_ENTRY_INC;
			s.cfg.bus_width_sel <= `LHCD_RST_WIDTH;
		end else begin
			s <= next_s;
		end
	end

	// ======================================================================
	// Outputs
	assign host_rdata = s.rdata;
	assign busy_bit = busy;
	assign addr_counter = s.ac;
	assign cfg = s.cfg;
	assign disp_shift_pulse = s.shift_pulse;
	assign disp_shift_left = s.shift_left;
	assign home_pulse = s.home_pulse;
	// RL22: cursor at counter text position.
	assign cursor_underline = s.cfg.cursor_on && s.cfg.display_on;
	assign cursor_blinking = s.cfg.cursor_blink && s.cfg.display_on;
	assign cursor_addr = s.ac;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	clear_busy_time_a: assert property (acc_clear |=> busy_bit ##165 !busy_bit) // RL13
		else $error("clear busy time wrong");
	short_busy_time_a: assert property (acc_short && !acc_clear |=> busy_bit [*3] ##1 !busy_bit) // RL10
		else $error("short busy time wrong");
	status_read_a: assert property (acc_stat |=> host_rdata == {$past(busy_bit), $past(addr_counter)}) // RL24
		else $error("status read wrong");
	busy_discard_a: assert property (busy_bit && acc_cmd == 1'b0 && req.valid && !req.rd && !req.reg_sel
		|=> cfg == $past(cfg)) // RL11
		else $error("command taken while busy");
	write_step_a: assert property (acc_wr && !s.clearing |=> addr_counter ==
		($past(cfg.entry_inc) ? $past(addr_counter) + 7'h01 : $past(addr_counter) - 7'h01)) // RL20
		else $error("counter not stepped");
	read_prefetch_a: assert property (acc_rd |=> host_rdata == $past(s.data_reg)) // RL19
		else $error("read not prefetched");
	read_refill_a: assert property (acc_rd |-> ##3 s.data_reg == $past(ram_rdata)) // RL26
		else $error("data not refilled");
	func_set_a: assert property (acc_fset |=> cfg.ext_mode == $past(req.data[0])) // RL15
		else $error("set select not applied");
	shift_write_a: assert property (acc_wr && cfg.entry_shift && !s.sel_glyph && !s.clearing
		|=> disp_shift_pulse) // RL21
		else $error("no shift on write");
	reserved_code_a: assert property (acc_cmd && cfg.ext_mode && req.data == `LHCD_CMD_CLEAR
		|=> !busy_bit && $stable(cfg) && $stable(addr_counter)) // RL27
		else $error("reserved code had effect");

	clear_cov_c: cover property (acc_clear ##166 !busy_bit);
	ext_cov_c: cover property (acc_fset && req.data[0]);
	read_cov_c: cover property (acc_rd ##[4:8] acc_rd);

endmodule

// File: lhcd_core_tb_top.sv
// Self-checking testbench of the command decoder core.
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module lhcd_core_tb_top;
	import lhcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic       ref_clk = 1'b0;
	logic       rst_n   = 1'b0;
	logic       par_stb, par_reg_sel, par_rd, ser_start, ser_rw, ser_valid, ser_rd_req;
	logic [7:0] par_wdata, ser_byte, host_rdata, q;
	logic       busy_bit, disp_shift_pulse, cur_ul, shift_left, home_p, cur_bl;
	logic [6:0] addr_counter, cursor_addr;
	lhcd_cfg_t  cfg, c0;
	int         fails, check_count, shifts, n;

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (disp_shift_pulse === 1'b1) shifts++;

	lhcd_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .par_stb(par_stb), .par_reg_sel(par_reg_sel),
		.par_rd(par_rd), .par_wdata(par_wdata), .ser_start(ser_start), .ser_rw(ser_rw),
		.ser_valid(ser_valid), .ser_byte(ser_byte), .ser_rd_req(ser_rd_req), .host_rdata(host_rdata),
		.busy_bit(busy_bit), .addr_counter(addr_counter), .cfg(cfg), .disp_shift_pulse(disp_shift_pulse),
		.disp_shift_left(shift_left), .home_pulse(home_p), .cursor_underline(cur_ul), .cursor_blinking(cur_bl),
		.cursor_addr(cursor_addr));

	lhcd_host host_u (.ref_clk(ref_clk), .busy_bit(busy_bit), .host_rdata(host_rdata), .par_stb(par_stb),
		.par_reg_sel(par_reg_sel), .par_rd(par_rd), .par_wdata(par_wdata), .ser_start(ser_start),
		.ser_rw(ser_rw), .ser_valid(ser_valid), .ser_byte(ser_byte), .ser_rd_req(ser_rd_req));

	task automatic t_fset();
		`CHK("reset", {1'b0, 7'h00, 1'b1, 1'b1}, {busy_bit, addr_counter, cfg.entry_inc, cfg.bus_width_sel})
		host_u.op(1'b0, 1'b0, 8'h36, q, n);
		`CHK("fset cycles", 3, n)
		`CHK("fset bits", 4'hE, {cfg.bus_width_sel, cfg.two_lines, cfg.low_mux_sel, cfg.ext_mode})
		host_u.op(1'b0, 1'b0, 8'h20, q, n);
		`CHK("fset clr", 4'h0, {cfg.bus_width_sel, cfg.two_lines, cfg.low_mux_sel, cfg.ext_mode})
		host_u.op(1'b0, 1'b0, 8'h00, q, n);
		`CHK("nop cycles", 3, n)
	endtask

	task automatic t_busy();
		host_u.op(1'b0, 1'b0, 8'h0C, q, n);
		host_u.pulse(1'b0, 1'b0, 8'h01);
		host_u.pulse(1'b0, 1'b1, 8'h00);
		`CHK("status busy", 1'b1, host_rdata[7])
		host_u.pulse(1'b0, 1'b0, 8'h08);
		host_u.pulse(1'b1, 1'b0, 8'h55);
		host_u.idle(n);
		`CHK("cmd dropped", 1'b1, cfg.display_on)
		host_u.op(1'b0, 1'b0, 8'h01, q, n);
		`CHK("clear cycles", 165, n)
		`CHK("clear ac", 7'h00, addr_counter)
	endtask

	task automatic t_rw();
		host_u.op(1'b0, 1'b0, 8'h85, q, n);
		host_u.op(1'b1, 1'b0, 8'h41, q, n);
		`CHK("write cycles", 3, n)
		host_u.op(1'b1, 1'b0, 8'h42, q, n);
		host_u.op(1'b0, 1'b1, 8'h00, q, n);
		`CHK("status ac", 8'h07, q)
		`CHK("status cycles", 0, n)
		`CHK("cursor pos", 7'h07, cursor_addr)
		host_u.op(1'b0, 1'b0, 8'h04, q, n);
		host_u.op(1'b0, 1'b0, 8'h86, q, n);
		host_u.op(1'b1, 1'b1, 8'h00, q, n);
		`CHK("prefetch", 8'h42, q)
		host_u.op(1'b1, 1'b1, 8'h00, q, n);
		`CHK("refill", 8'h41, q)
		host_u.op(1'b0, 1'b1, 8'h00, q, n);
		`CHK("ac down", 8'h04, q)
	endtask

	task automatic t_shift();
		int s;
		host_u.op(1'b0, 1'b0, 8'h0E, q, n);
		`CHK("underline", 1'b1, cur_ul)
		host_u.op(1'b0, 1'b0, 8'h05, q, n);
		s = shifts;
		host_u.op(1'b1, 1'b0, 8'h20, q, n);
		`CHK("shift count", s + 1, shifts)
		`CHK("shift right", 1'b0, shift_left)
		host_u.op(1'b0, 1'b0, 8'h18, q, n);
		`CHK("shift left", 1'b1, shift_left)
		host_u.op(1'b0, 1'b0, 8'h0F, q, n);
		`CHK("blink", 1'b1, cur_bl)
		host_u.pulse(1'b0, 1'b0, 8'h02);
		`CHK("home pulse", 1'b1, home_p)
		host_u.idle(n);
		`CHK("home ac", 7'h00, addr_counter)
		host_u.op(1'b0, 1'b0, 8'h06, q, n);
	endtask

	task automatic t_ext();
		logic [7:0] codes [7] = '{8'h03, 8'h06, 8'h0D, 8'h13, 8'h42, 8'hC5, 8'h8A};
		host_u.op(1'b0, 1'b0, 8'h35, q, n);
		`CHK("ext on", 1'b1, cfg.ext_mode)
		c0 = cfg;
		host_u.op(1'b0, 1'b0, 8'h01, q, n);
		`CHK("reserved busy", 0, n)
		`CHK("reserved cfg", c0, cfg)
		foreach (codes[i]) host_u.op(1'b0, 1'b0, codes[i], q, n);
		`CHK("ext bits", 10'h35E, {cfg.screen_l, cfg.disp_p, cfg.disp_q, cfg.symbol_only_mode, cfg.symbol_blink,
			cfg.direct_drive, cfg.tempco_hi, cfg.tempco_lo, cfg.pump_hi, cfg.pump_lo})
		`CHK("levels", 12'h285, {cfg.level_a, cfg.level_b})
		host_u.op(1'b0, 1'b0, 8'h34, q, n);
		`CHK("ext off", 1'b0, cfg.ext_mode)
	endtask

	task automatic t_ser();
		host_u.start(1'b0);
		host_u.sbyte(host_u.ctrl(1'b1, 1'b0));
		host_u.sbyte(8'h90);
		host_u.sbyte(host_u.ctrl(1'b0, 1'b1));
		host_u.sbyte(8'h61);
		host_u.sbyte(8'h62);
		host_u.start(1'b0);
		host_u.sbyte(host_u.ctrl(1'b0, 1'b0));
		host_u.start(1'b1);
		host_u.sread(q);
		`CHK("ser status", 8'h12, q)
		host_u.start(1'b0);
		host_u.sbyte(host_u.ctrl(1'b0, 1'b0));
		host_u.sbyte(8'h91);
		host_u.start(1'b0);
		host_u.sbyte(host_u.ctrl(1'b0, 1'b1));
		host_u.start(1'b1);
		host_u.sread(q);
		`CHK("ser data", 8'h62, q)
	endtask

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		t_fset();
		t_busy();
		t_rw();
		t_shift();
		t_ext();
		t_ser();
		give_verdict();
	end
endmodule

// File: lhcd_host.sv
// Host controller model driving the parallel and serial ports of the decoder.
module lhcd_host
	import lhcd_pkg::*;
(
	// Clock and status
	input  wire logic       ref_clk,
	input  wire logic       busy_bit,
	input  wire logic [7:0] host_rdata,
	// Parallel port
	output logic            par_stb,
	output logic            par_reg_sel,
	output logic            par_rd,
	output logic [7:0]      par_wdata,
	// Serial port
	output logic            ser_start,
	output logic            ser_rw,
	output logic            ser_valid,
	output logic [7:0]      ser_byte,
	output logic            ser_rd_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{par_stb, par_reg_sel, par_rd, par_wdata} = 11'h000;
		{ser_start, ser_rw, ser_valid, ser_byte, ser_rd_req} = 12'h000;
	end

	task automatic pulse(input logic sel, input logic rd, input logic [7:0] d);
		@(negedge ref_clk);
		par_stb     = 1'b1;
		par_reg_sel = sel;
		par_rd      = rd;
		par_wdata   = d;
		@(negedge ref_clk);
		par_stb   = 1'b0;
		par_wdata = ~d;
	endtask

	task automatic idle(output int n);
		n = 0;
		while (busy_bit === 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic op(input logic sel, input logic rd, input logic [7:0] d, output logic [7:0] q, output int n);
		pulse(sel, rd, d);
		q = host_rdata;
		idle(n);
	endtask

	function automatic logic [7:0] ctrl(input logic more, input logic sel);
		return {more, sel, 6'h00};
	endfunction

	task automatic start(input logic rw);
		@(negedge ref_clk);
		ser_rw    = rw;
		ser_start = 1'b1;
		@(negedge ref_clk);
		ser_start = 1'b0;
	endtask

	task automatic sbyte(input logic [7:0] b);
		int n;
		@(negedge ref_clk);
		ser_valid = 1'b1;
		ser_byte  = b;
		@(negedge ref_clk);
		ser_valid = 1'b0;
		ser_byte  = ~b;
		idle(n);
	endtask

	task automatic sread(output logic [7:0] q);
		int n;
		@(negedge ref_clk);
		ser_rd_req = 1'b1;
		@(negedge ref_clk);
		ser_rd_req = 1'b0;
		q = host_rdata;
		idle(n);
	endtask
endmodule

// File: lhcd_pkg.sv
// Types shared by the command decoder modules.
package lhcd_pkg;

	// Host request as seen by the decoder core.
	typedef struct packed {
		logic       valid;
		logic       reg_sel;
		logic       rd;
		logic [7:0] data;
	} lhcd_req_t;

	// Serial control byte tracker state.
	typedef struct packed {
		logic expect_ctrl;
		logic more;
		logic reg_sel;
	} lhcd_ser_t;

	// Display configuration held by the decoder.
	typedef struct packed {
		logic       bus_width_sel;
		logic       two_lines;
		logic       low_mux_sel;
		logic       ext_mode;
		logic       entry_inc;
		logic       entry_shift;
		logic       display_on;
		logic       cursor_on;
		logic       cursor_blink;
		logic       screen_l;
		logic       disp_p;
		logic       disp_q;
		logic       symbol_only_mode;
		logic       symbol_blink;
		logic       direct_drive;
		logic       tempco_hi;
		logic       tempco_lo;
		logic       pump_hi;
		logic       pump_lo;
		logic [5:0] level_a;
		logic [5:0] level_b;
	} lhcd_cfg_t;

	// Whole state of the decoder core.
	typedef struct packed {
		logic [7:0] busy_cnt;
		logic [6:0] ac;
		logic [7:0] ir;
		logic [7:0] data_reg;
		logic [7:0] rdata;
		logic       sel_glyph;
		logic       fetch_req;
		logic       fetch_load;
		logic       clearing;
		logic [6:0] clr_idx;
		logic       shift_pulse;
		logic       shift_left;
		logic       home_pulse;
		lhcd_cfg_t  cfg;
	} lhcd_core_t;

endpackage

// File: lhcd_ram.sv
// Combined text and glyph RAM with registered read data.
module lhcd_ram
	import lhcd_pkg::*;
#(
	parameter int AW = 8
) (
	// Clock
	input  wire logic          ref_clk,
	// Access
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);

	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

// File: lhcd_regs.svh
// Encodings, field positions, command codes, reset values and cycle counts of the command decoder.
`ifndef LHCD_REGS_SVH
`define LHCD_REGS_SVH

// ==========================================================================
// Register select and direction encodings
`define LHCD_SEL_INSTR      1'b0
`define LHCD_SEL_DATA       1'b1
`define LHCD_DIR_WRITE      1'b0
`define LHCD_DIR_READ       1'b1

// ==========================================================================
// Control byte fields on the serial link
`define LHCD_CTRL_MORE_BIT  7
`define LHCD_CTRL_SEL_BIT   6

// ==========================================================================
// Function set fields
`define LHCD_FS_WIDTH_BIT   4
`define LHCD_FS_LINES_BIT   2
`define LHCD_FS_MUX_BIT     1
`define LHCD_FS_EXT_BIT     0

// ==========================================================================
// Command codes
`define LHCD_CMD_NOP        8'h00
`define LHCD_CMD_CLEAR      8'h01
`define LHCD_BLANK_CHAR     8'h20

// ==========================================================================
// Execution times in oscillator cycles
`define LHCD_CYC_SHORT      8'h03
`define LHCD_CYC_CLEAR      8'hA5
`define LHCD_CYC_STATUS     8'h00

// ==========================================================================
// Reset values
`define LHCD_RST_ENTRY_INC  1'b1
`define LHCD_RST_WIDTH      1'b1

`endif

// File: lhcd_ser.sv
// Serial link front end that splits control bytes from payload bytes.
module lhcd_ser
	import lhcd_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Byte stream from the serial link
	input  wire logic       ser_start,
	input  wire logic       ser_rw,
	input  wire logic       ser_valid,
	input  wire logic [7:0] ser_byte,
	input  wire logic       ser_rd_req,
	// Request to the core
	output lhcd_req_t       req
);

	lhcd_ser_t s;
	lhcd_ser_t next_s;

	always_comb begin
		next_s = s;
		req = '0;
		if (ser_start) begin
			next_s.expect_ctrl = 1'b1;
			next_s.more = 1'b1;
		end else if (ser_valid && !ser_rw) begin
			if (s.expect_ctrl) begin
				// RL7: continuation bit.
				next_s.more = ser_byte[`LHCD_CTRL_MORE_BIT];
				// RL8: register select bit.
				next_s.reg_sel = ser_byte[`LHCD_CTRL_SEL_BIT];
				next_s.expect_ctrl = 1'b0;
			end else begin
				// RL6: payload after control byte.
				req.valid = 1'b1;
				req.reg_sel = s.reg_sel;
				req.rd = `LHCD_DIR_WRITE;
				req.data = ser_byte;
				next_s.expect_ctrl = s.more;
			end
		end else if (ser_rd_req && ser_rw) begin
			// RL9: direction from address byte.
			req.valid = 1'b1;
			req.reg_sel = s.reg_sel;
			req.rd = `LHCD_DIR_READ;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
